//--- hdl/vbs_pkg.sv
// constants for the vector base select control block
package vbs_pkg;
  localparam logic [7:0]  MCU_CONTROL_ADDR = 8'h35;
  localparam logic [7:0]  MCU_CONTROL_RST  = 8'h00;
  localparam int          BIT_ARM          = 0;
  localparam int          BIT_SEL          = 1;
  localparam int          BIT_PULLUP_OFF   = 4;
  localparam int          BIT_DEBUG_DIS    = 7;
  localparam logic [7:0]  WRITABLE_MASK    = 8'h93;
  localparam int          WINDOW_CYCLES    = 4;
  localparam logic [2:0]  WINDOW_CNT       = 3'h4;
  localparam logic [15:0] FLASH_START      = 16'h0000;
  localparam logic [15:0] VECTOR_OFFSET    = 16'h0002;
  localparam logic [15:0] BOOT_8K_START    = 16'hf000;
  localparam logic [1:0]  PIN_PULLUP_CFG   = 2'h1;
  localparam logic [1:0]  BOOT_SIZE_8K     = 2'h0;
endpackage : vbs_pkg

//--- hdl/vbs_window.sv
// down-counter that holds a protected-write window open for a few cycles
`timescale 1ns/1ps
module vbs_window #(
  parameter logic [2:0] COUNT = 3'h4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic start,
  input  wire logic stop,
  // state
  output logic      open_now
);
  logic [2:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 3'h0;
    end else if (stop) begin
      cnt_reg <= 3'h0;
    end else if (start) begin
      cnt_reg <= COUNT;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  assign open_now = (cnt_reg != 3'h0);

  a_window_bound: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_reg <= COUNT) else $error("window counter above its load");
endmodule : vbs_window

//--- hdl/vbs_ctrl.sv
// mcu control register: vector select, debug disable, pull-up off
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - select bit zero: vectors start at flash start
// - select bit one: vectors start at boot section from size fuses
// - select bit written only while arm bit set, else kept
// - arm bit clears five cycles after set or on select write
// - interrupts blocked from arming until after next instruction
// - unwritten select: interrupts blocked six cycles then allowed
// - automatic block leaves global interrupt enable untouched
// - boot vectors plus app lock: block interrupts in application code
// - app vectors plus boot lock: block interrupts in boot code
// - debug port on only if fuse programmed and disable bit zero
// - debug disable changes only on equal double write within four cycles
// - pull-up off bit kills all port pull-ups
// - reserved bits read zero, ignore writes; register resets zero
// - boot reset with 8K boot: reset 0xf000; vectors 0xf002 only with select bit one
// - boot reset fuse one unprogrammed, zero programmed
module vbs_ctrl #(
  parameter logic [15:0] BOOT_START_16K = 16'he000,
  parameter logic [15:0] BOOT_START_32K = 16'hc000,
  parameter logic [15:0] BOOT_START_64K = 16'h8000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  // fuses and lock bits (0 = programmed)
  input  wire logic        boot_reset_fuse,
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        app_side_lock_bit,
  input  wire logic        boot_side_lock_bit,
  input  wire logic        debug_port_fuse,
  // cpu status
  input  wire logic        exec_in_boot,
  input  wire logic        instr_done,
  input  wire logic        global_int_en,
  // results
  output logic      [15:0] reset_vector,
  output logic      [15:0] vector_base,
  output logic             int_allowed,
  output logic             debug_port_on,
  output logic             global_pullup_off,
  // pull-up gating, one bit per pin
  input  wire logic        pin_direction_bit,
  input  wire logic        pin_output_bit,
  output logic             pin_pullup_on
);
  logic        ctl_wr;
  logic        arm_reg;
  logic        sel_reg;
  logic        dbg_reg;
  logic        pud_reg;
  logic        arm_open;
  logic        sel_written;
  logic        dbg_open;
  logic        dbg_pend_reg;
  logic        hold_reg;
  logic        lock_block;
  logic [15:0] boot_start;

  assign ctl_wr = wr_stb && (addr == vbs_pkg::MCU_CONTROL_ADDR);
  // select write counts only with arm bit written zero
  assign sel_written = ctl_wr && arm_reg && !wdata[vbs_pkg::BIT_ARM];

  vbs_window #(.COUNT(vbs_pkg::WINDOW_CNT)) u_arm_win (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (ctl_wr && wdata[vbs_pkg::BIT_ARM]),
    .stop     (sel_written),
    .open_now (arm_open)
  );

  vbs_window #(.COUNT(vbs_pkg::WINDOW_CNT)) u_dbg_win (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (ctl_wr && !dbg_open),
    .stop     (ctl_wr && dbg_open),
    .open_now (dbg_open)
  );

  // arm bit: set on write, cleared by window end or select write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arm_reg <= 1'b0;
    end else if (ctl_wr && wdata[vbs_pkg::BIT_ARM]) begin
      arm_reg <= 1'b1;
    end else if (sel_written || (arm_reg && !arm_open)) begin
      arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_reg <= 1'b0;
    end else if (sel_written) begin
      sel_reg <= wdata[vbs_pkg::BIT_SEL];
    end
  end

  // keep blocking until the instruction after the select write retires
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_reg <= 1'b0;
    end else if (sel_written) begin
      hold_reg <= 1'b1;
    end else if (instr_done) begin
      hold_reg <= 1'b0;
    end
  end

  // debug disable: first write records value, second equal one commits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dbg_pend_reg <= 1'b0;
    end else if (ctl_wr && !dbg_open) begin
      dbg_pend_reg <= wdata[vbs_pkg::BIT_DEBUG_DIS];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dbg_reg <= 1'b0;
    end else if (ctl_wr && dbg_open &&
                 wdata[vbs_pkg::BIT_DEBUG_DIS] == dbg_pend_reg) begin
      dbg_reg <= dbg_pend_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pud_reg <= 1'b0;
    end else if (ctl_wr) begin
      pud_reg <= wdata[vbs_pkg::BIT_PULLUP_OFF];
    end
  end

  // read data, reserved bits zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= vbs_pkg::MCU_CONTROL_RST;
    end else if (rd_stb && addr == vbs_pkg::MCU_CONTROL_ADDR) begin
      rdata <= {dbg_reg, 2'h0, pud_reg, 2'h0, sel_reg, arm_reg};
    end else begin
      rdata <= 8'h00;
    end
  end

  always_comb begin
    unique case (boot_size_fuses)
      vbs_pkg::BOOT_SIZE_8K: boot_start = vbs_pkg::BOOT_8K_START;
      2'h1:    boot_start = BOOT_START_16K;
      2'h2:    boot_start = BOOT_START_32K;
      default: boot_start = BOOT_START_64K;
    endcase
  end

  // lock bits programmed (zero) block interrupts in the other section
  assign lock_block = (sel_reg && !app_side_lock_bit && !exec_in_boot)
                   || (!sel_reg && !boot_side_lock_bit && exec_in_boot);

  // reset vector from the boot reset fuse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_vector <= vbs_pkg::FLASH_START;
    end else begin
      reset_vector <= boot_reset_fuse ? vbs_pkg::FLASH_START
                                      : boot_start;
    end
  end

  // first interrupt vector address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vector_base <= vbs_pkg::FLASH_START;
    end else begin
      vector_base <= sel_reg ? boot_start + vbs_pkg::VECTOR_OFFSET
                             : vbs_pkg::VECTOR_OFFSET;
    end
  end

  // global enable only read, never written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_allowed <= 1'b0;
    end else begin
      int_allowed <= global_int_en && !lock_block && !hold_reg
                     && !sel_written
                     && !(arm_reg || (ctl_wr && wdata[vbs_pkg::BIT_ARM]));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      debug_port_on <= 1'b0;
    end else begin
      debug_port_on <= !debug_port_fuse && !dbg_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_pullup_off <= 1'b0;
    end else begin
      global_pullup_off <= pud_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_pullup_on <= 1'b0;
    end else begin
      pin_pullup_on <= !pud_reg && ({pin_direction_bit, pin_output_bit}
                       == vbs_pkg::PIN_PULLUP_CFG);
    end
  end

  a_arm_clears: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(arm_reg) |-> ##[1:5] !arm_reg)
    else $error("arm bit outlived its window");
  a_sel_guard: assert property (@(posedge clk) disable iff (sys_rst)
    !arm_reg |=> $stable(sel_reg))
    else $error("select changed without arming");
  a_arm_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    arm_reg |=> !int_allowed)
    else $error("interrupt allowed while armed");
  a_dbg_single: assert property (@(posedge clk) disable iff (sys_rst)
    !dbg_open |=> $stable(dbg_reg))
    else $error("debug disable changed on single write");
  a_pullup_off: assert property (@(posedge clk) disable iff (sys_rst)
    pud_reg |=> !pin_pullup_on)
    else $error("pull-up on while disabled");
  a_vec_base: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_reg && $past(!sel_reg) |=> vector_base == vbs_pkg::VECTOR_OFFSET)
    else $error("vector base not flash start");
  a_debug_port: assert property (@(posedge clk) disable iff (sys_rst)
    dbg_reg |=> !debug_port_on)
    else $error("debug port on while disabled");
  a_gie_needed: assert property (@(posedge clk) disable iff (sys_rst)
    !global_int_en |=> !int_allowed)
    else $error("interrupt allowed without global enable");
  a_boot_base: assert property (@(posedge clk) disable iff (sys_rst)
    sel_reg && boot_size_fuses == vbs_pkg::BOOT_SIZE_8K |=>
    vector_base == vbs_pkg::BOOT_8K_START + vbs_pkg::VECTOR_OFFSET)
    else $error("vector base not boot start");
  a_boot_reset: assert property (@(posedge clk) disable iff (sys_rst)
    !boot_reset_fuse && boot_size_fuses == vbs_pkg::BOOT_SIZE_8K |=>
    reset_vector == vbs_pkg::BOOT_8K_START)
    else $error("reset vector not boot start");
  a_flash_reset: assert property (@(posedge clk) disable iff (sys_rst)
    boot_reset_fuse |=> reset_vector == vbs_pkg::FLASH_START)
    else $error("reset vector not flash start");
  a_app_lock: assert property (@(posedge clk) disable iff (sys_rst)
    sel_reg && !app_side_lock_bit && !exec_in_boot |=> !int_allowed)
    else $error("interrupt allowed in locked application");
  a_boot_lock: assert property (@(posedge clk) disable iff (sys_rst)
    !sel_reg && !boot_side_lock_bit && exec_in_boot |=> !int_allowed)
    else $error("interrupt allowed in locked boot code");
  a_hold_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    hold_reg |=> !int_allowed)
    else $error("interrupt allowed before next instruction");
  a_arm_int: assert property (@(posedge clk) disable iff (sys_rst)
    ctl_wr && wdata[vbs_pkg::BIT_ARM] |=> !int_allowed && arm_reg)
    else $error("arming did not block interrupts");
  a_sel_clears: assert property (@(posedge clk) disable iff (sys_rst)
    sel_written |=> !arm_reg)
    else $error("arm bit kept after select write");
  a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
    sel_written |=> sel_reg == $past(wdata[vbs_pkg::BIT_SEL]))
    else $error("armed select write lost");
  a_dbg_change: assert property (@(posedge clk) disable iff (sys_rst)
    dbg_reg != $past(dbg_reg) |-> $past(dbg_open))
    else $error("debug disable changed outside window");
  a_rd_reserved: assert property (@(posedge clk) disable iff (sys_rst)
    (rdata & ~vbs_pkg::WRITABLE_MASK) == 8'h00)
    else $error("reserved bits read nonzero");
  a_rd_other: assert property (@(posedge clk) disable iff (sys_rst)
    rd_stb && addr != vbs_pkg::MCU_CONTROL_ADDR |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_debug_fuse: assert property (@(posedge clk) disable iff (sys_rst)
    debug_port_fuse |=> !debug_port_on)
    else $error("debug port on without fuse");
  a_pud_out: assert property (@(posedge clk) disable iff (sys_rst)
    pud_reg |=> global_pullup_off)
    else $error("pull-up off output not set");
  a_pullup_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    !pud_reg && {pin_direction_bit, pin_output_bit} ==
    vbs_pkg::PIN_PULLUP_CFG |=> pin_pullup_on)
    else $error("pull-up missing while enabled");
endmodule : vbs_ctrl

//--- tb/vbs_ctrl_test.sv
// self-checking bench for the mcu control register block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module vbs_ctrl_test;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rdata;
  logic        boot_reset_fuse = 1'b1;
  logic [1:0]  boot_size_fuses = 2'h0;
  logic        app_side_lock_bit = 1'b1;
  logic        boot_side_lock_bit = 1'b1;
  logic        debug_port_fuse = 1'b0;
  logic        exec_in_boot = 1'b0;
  logic        instr_done = 1'b0;
  logic        global_int_en = 1'b1;
  logic [15:0] reset_vector;
  logic [15:0] vector_base;
  logic        int_allowed;
  logic        debug_port_on;
  logic        global_pullup_off;
  logic        pin_direction_bit = 1'b0;
  logic        pin_output_bit = 1'b1;
  logic        pin_pullup_on;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;
  localparam logic [7:0] A = vbs_pkg::MCU_CONTROL_ADDR;

  vbs_ctrl dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
    .app_side_lock_bit(app_side_lock_bit),
    .boot_side_lock_bit(boot_side_lock_bit),
    .debug_port_fuse(debug_port_fuse), .exec_in_boot(exec_in_boot),
    .instr_done(instr_done), .global_int_en(global_int_en),
    .reset_vector(reset_vector), .vector_base(vector_base),
    .int_allowed(int_allowed), .debug_port_on(debug_port_on),
    .global_pullup_off(global_pullup_off),
    .pin_direction_bit(pin_direction_bit), .pin_output_bit(pin_output_bit),
    .pin_pullup_on(pin_pullup_on));

  always #10 clk = ~clk;

  task report_and_stop;
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // idle cycles with both strobes low
  task cyc(input int n);
    repeat (n) @(posedge clk) begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
    end
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge clk);
    addr   <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask : rd

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(3);
    rd(A, 8'h00, "reset value");
    `CHK("int idle", 1'b1, int_allowed)
    `CHK("debug on", 1'b1, debug_port_on)
    `CHK("flash base", 16'h0002, vector_base)
    `CHK("reset vec", 16'h0000, reset_vector)
    wr(A, 8'hff);
    cyc(2);
    `CHK("int armed", 1'b0, int_allowed)
    rd(A, 8'h11, "armed value");
    cyc(6);
    rd(A, 8'h10, "arm expired");
    `CHK("int back", 1'b1, int_allowed)
    `CHK("pud", 1'b1, global_pullup_off)
    `CHK("pullup off", 1'b0, pin_pullup_on)
    wr(A, 8'h00);
    cyc(3);
    `CHK("pullup on", 1'b1, pin_pullup_on)
    wr(A, 8'h01);
    wr(A, 8'h02);
    cyc(3);
    `CHK("int held", 1'b0, int_allowed)
    `CHK("boot base", 16'hf002, vector_base)
    @(posedge clk) instr_done <= 1'b1;
    @(posedge clk) instr_done <= 1'b0;
    cyc(3);
    `CHK("int after", 1'b1, int_allowed)
    `CHK("gie kept", 1'b1, global_int_en)
    rd(A, 8'h02, "moved");
    wr(A, 8'h00);
    cyc(6);
    rd(A, 8'h02, "unarmed sel");
    wr(A, 8'h82);
    wr(A, 8'h82);
    cyc(3);
    rd(A, 8'h82, "debug dis");
    `CHK("debug off", 1'b0, debug_port_on)
    wr(8'h36, 8'h10);
    cyc(1);
    rd(8'h36, 8'h00, "unmapped");
    rd(A, 8'h82, "unmapped wr");
    boot_reset_fuse <= 1'b0;
    cyc(4);
    `CHK("boot reset", 16'hf000, reset_vector)
    app_side_lock_bit <= 1'b0;
    cyc(4);
    `CHK("app lock", 1'b0, int_allowed)
    exec_in_boot <= 1'b1;
    cyc(4);
    `CHK("boot exec", 1'b1, int_allowed)
    boot_side_lock_bit <= 1'b0;
    cyc(4);
    `CHK("boot lock sel", 1'b1, int_allowed)
    wr(A, 8'h81);
    wr(A, 8'h80);
    @(posedge clk) instr_done <= 1'b1;
    @(posedge clk) instr_done <= 1'b0;
    cyc(3);
    `CHK("boot lock", 1'b0, int_allowed)
    `CHK("flash base2", 16'h0002, vector_base)
    rd(A, 8'h80, "moved back");
    report_and_stop();
  end
endmodule : vbs_ctrl_test
